// File: hdl/feature_pkg.sv
// Purpose: shared constants and types for reserved feature negotiation
// Assumes: 64-bit feature vectors, 20 MHz clock
// Notes: bit positions of device-independent reserved features
`default_nettype none
package feature_pkg;
  localparam int unsigned FEAT_W = 64;
  localparam int unsigned NOTIFY_EMPTY_BIT = 24;
  localparam int unsigned ANY_LAYOUT_BIT = 27;
  localparam int unsigned EARLY_BROKEN_BIT = 30;
  localparam int unsigned COMPLIANCE_BIT = 32;
  localparam int unsigned PLATFORM_ACCESS_BIT = 33;
  localparam int unsigned IN_ORDER_BIT = 35;
  localparam int unsigned ORDER_PLATFORM_BIT = 36;
  localparam int unsigned SRIOV_BIT = 37;
  localparam int unsigned ADDR_W = 4;
  // register offsets, one word each
  localparam logic [3:0] OFF_OFFER_LO = 4'h0;
  localparam logic [3:0] OFF_OFFER_HI = 4'h1;
  localparam logic [3:0] OFF_ACCEPT_LO = 4'h2;
  localparam logic [3:0] OFF_ACCEPT_HI = 4'h3;
  localparam logic [3:0] OFF_NEG_LO = 4'h4;
  localparam logic [3:0] OFF_NEG_HI = 4'h5;
  localparam logic [3:0] OFF_CTRL = 4'h6;
  localparam logic [3:0] OFF_STATE = 4'h7;
  localparam logic [3:0] OFF_IRQ_STATUS = 4'h8;
  localparam logic [3:0] OFF_IRQ_ENABLE = 4'h9;
  localparam logic [3:0] OFF_IRQ_CLEAR = 4'ha;
  localparam logic [3:0] OFF_OPTIONS = 4'hb;
  // ctrl bits
  localparam int unsigned CTRL_COMMIT = 0;
  localparam int unsigned CTRL_STRICT_ACCESS = 1;
  localparam int unsigned CTRL_STRICT_ORDER = 2;
  // option bits (software may lower offers it would otherwise make)
  localparam int unsigned OPT_NOTIFY_EMPTY = 0;
  localparam int unsigned OPT_ORDER_PLATFORM = 1;
  // irq bits
  localparam int unsigned IRQ_W = 4;
  localparam int unsigned IRQ_COMMIT = 0;
  localparam int unsigned IRQ_FAILED = 1;
  localparam int unsigned IRQ_EMPTY_NOTIFY = 2;
  localparam int unsigned IRQ_ORDER_ERR = 3;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] OPTIONS_RESET = 32'h0000_0003;

  typedef enum {ST_IDLE, ST_RUN, ST_EMULATED, ST_FAILED} neg_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic compliance;
    logic platform_access;
    logic in_order;
    logic order_platform;
    logic sriov;
    logic notify_empty;
    logic any_layout;
  } neg_flags_t;
endpackage
`default_nettype wire

// File: hdl/irq_block.sv
// Purpose: sticky event status, enable mask, level interrupt
// Assumes: single clock domain
// Notes: a set in the same cycle as a clear wins
`default_nettype none
module irq_block
  import feature_pkg::*;
#(
  parameter int unsigned WIDTH = IRQ_W
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic enable_in,
  input wire logic [WIDTH-1:0] event_in,
  input wire logic [WIDTH-1:0] clear_in,
  input wire logic enable_wr_in,
  input wire logic [WIDTH-1:0] enable_data_in,
  output logic [WIDTH-1:0] status_out,
  output logic [WIDTH-1:0] mask_out,
  output logic irq_out
);
  initial begin
    if (WIDTH < 1 || WIDTH > 32) $error("irq_block: WIDTH out of range");
  end
  wire logic [WIDTH-1:0] next_status = (status_out & ~clear_in) | event_in;

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      status_out <= '0;
      mask_out <= '0;
    end else if (enable_in) begin
      status_out <= next_status;
      if (enable_wr_in) begin
        mask_out <= enable_data_in;
      end
    end
  end
  assign irq_out = |(status_out & mask_out);
endmodule
`default_nettype wire

// File: hdl/order_tracker.sv
// Purpose: checks that buffers are marked used in availability order
// Assumes: each buffer carries a ring index that wraps at 2^IDX_W
// Notes: only an expected-index counter, no queue storage needed
`default_nettype none
module order_tracker
  import feature_pkg::*;
#(
  parameter int unsigned IDX_W = 16
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic enable_in,
  input wire logic active_in,
  input wire logic used_valid_in,
  input wire logic [IDX_W-1:0] used_idx_in,
  output logic order_ok_out,
  output logic order_err_out,
  output logic [IDX_W-1:0] expected_out
);
  initial begin
    if (IDX_W < 1 || IDX_W > 32) $error("order_tracker: IDX_W out of range");
  end
  wire logic mismatch = active_in && used_valid_in && (used_idx_in != expected_out);
  assign order_ok_out = !active_in || (used_idx_in == expected_out);

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      expected_out <= '0;
      order_err_out <= 1'b0;
    end else if (enable_in) begin
      order_err_out <= mismatch;
      if (!active_in) begin
        expected_out <= '0;
      end else if (used_valid_in && !mismatch) begin
        expected_out <= expected_out + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// File: hdl/feature_negotiation.sv
// Purpose: decides offered reserved features and device policy after negotiation
// Assumes: driver accepted set written by the transport over the register port
// Notes: offer straps are sampled continuously; a commit that passes policy latches the negotiated set
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Function
// RULE1 - always offer the compliance feature
// RULE2 - compliance declined: device may stop operating
// RULE3 - offer platform access when translated; else fail (code fails only with CTRL_STRICT_ACCESS set)
// RULE4 - in-order negotiated: use buffers in order
// RULE5 - ordering declined: stop or emulated mode
// RULE6 - add-in PCI card offers access and ordering
// RULE7 - offer SR-IOV only with SR-IOV capability
// RULE8 - notify-on-empty: notify when ring runs empty
// RULE9 - transitional device offers arbitrary layout bit
// RULE10 - transitional driver accepts arbitrary layout bit
// RULE11 - bit 30 is never negotiated
// RULE12 - compliance bit 32, platform access bit 33
// RULE13 - in-order 35, ordering 36, SR-IOV 37
// RULE14 - negotiated means offered and accepted both
module feature_negotiation
  import feature_pkg::*;
#(
  parameter int unsigned IDX_W = 16
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  input wire logic transitional_in,
  input wire logic translated_access_in,
  input wire logic pci_addin_card_in,
  input wire logic is_pci_in,
  input wire logic sriov_capability_in,
  input wire logic in_order_support_in,
  input wire logic ring_empty_in,
  input wire logic notify_suppressed_in,
  input wire logic used_valid_in,
  input wire logic [IDX_W-1:0] used_idx_in,
  output logic [FEAT_W-1:0] offered_out,
  output logic [FEAT_W-1:0] negotiated_out,
  output logic device_run_out,
  output logic device_failed_out,
  output logic emulation_mode_out,
  output logic in_order_active_out,
  output logic used_notify_out,
  output logic order_ok_out,
  output logic irq_out
);
  initial begin
    if (IDX_W < 1 || IDX_W > 32) $error("feature_negotiation: IDX_W out of range");
  end

  //////////////////////////////////////////////////////////////////////////////
  // register port
  reg_req_t req;
  assign req = '{wr: wr_in, rd: rd_in, addr: addr_in, wdata: wdata_in};

  logic [FEAT_W-1:0] accepted;
  logic [31:0] ctrl;
  logic [31:0] options;
  neg_state_t state;
  neg_flags_t flags;

  wire logic wr_accept_lo = req.wr && (req.addr == OFF_ACCEPT_LO);
  wire logic wr_accept_hi = req.wr && (req.addr == OFF_ACCEPT_HI);
  wire logic wr_ctrl = req.wr && (req.addr == OFF_CTRL);
  wire logic wr_options = req.wr && (req.addr == OFF_OPTIONS);
  wire logic wr_irq_enable = req.wr && (req.addr == OFF_IRQ_ENABLE);
  wire logic wr_irq_clear = req.wr && (req.addr == OFF_IRQ_CLEAR);
  wire logic commit = wr_ctrl && req.wdata[CTRL_COMMIT];

  //////////////////////////////////////////////////////////////////////////////
  // offered feature vector
  wire logic offer_access = translated_access_in || pci_addin_card_in; // RULE3 RULE6
  wire logic offer_order = options[OPT_ORDER_PLATFORM] || pci_addin_card_in; // RULE6
  wire logic offer_sriov = is_pci_in && sriov_capability_in; // RULE7
  wire logic offer_empty = transitional_in && options[OPT_NOTIFY_EMPTY]; // RULE8

  logic [FEAT_W-1:0] next_offered;
  always_comb begin
    next_offered = '0;
    next_offered[COMPLIANCE_BIT] = 1'b1; // RULE1 RULE12
    next_offered[PLATFORM_ACCESS_BIT] = offer_access; // RULE12
    next_offered[IN_ORDER_BIT] = in_order_support_in; // RULE13
    next_offered[ORDER_PLATFORM_BIT] = offer_order; // RULE13
    next_offered[SRIOV_BIT] = offer_sriov; // RULE13
    next_offered[NOTIFY_EMPTY_BIT] = offer_empty;
    next_offered[ANY_LAYOUT_BIT] = transitional_in; // RULE9
    next_offered[EARLY_BROKEN_BIT] = 1'b0; // RULE11
  end

  // bit 30 masked even if the driver sets it
  wire logic [FEAT_W-1:0] next_negotiated =
    next_offered & accepted & ~(64'h1 << EARLY_BROKEN_BIT); // RULE14 RULE11

  //////////////////////////////////////////////////////////////////////////////
  // policy evaluated at commit
  wire logic miss_compliance = !next_negotiated[COMPLIANCE_BIT]; // RULE2
  wire logic miss_access = next_offered[PLATFORM_ACCESS_BIT]
    && !next_negotiated[PLATFORM_ACCESS_BIT]; // RULE3
  wire logic miss_order = next_offered[ORDER_PLATFORM_BIT]
    && !next_negotiated[ORDER_PLATFORM_BIT]; // RULE5
  // a transitional driver should take this; refusing it is a driver fault
  wire logic miss_layout = next_offered[ANY_LAYOUT_BIT]
    && !next_negotiated[ANY_LAYOUT_BIT]; // RULE10
  wire logic commit_fail = miss_compliance || miss_layout
    || (miss_access && ctrl[CTRL_STRICT_ACCESS])
    || (miss_order && ctrl[CTRL_STRICT_ORDER]); // RULE2 RULE3 RULE5

  neg_state_t next_state;
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE, ST_RUN, ST_EMULATED: begin
        if (commit) begin
          if (commit_fail) begin
            next_state = ST_FAILED;
          end else if (miss_order) begin
            next_state = ST_EMULATED; // RULE5
          end else begin
            next_state = ST_RUN;
          end
        end
      end
      ST_FAILED: begin
        // stays failed until reset: refuses further service
        next_state = ST_FAILED;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      accepted <= '0;
      ctrl <= CTRL_RESET;
      options <= OPTIONS_RESET;
      state <= ST_IDLE;
      offered_out <= '0;
      negotiated_out <= '0;
    end else if (clk_en_in) begin
      offered_out <= next_offered;
      state <= next_state;
      if (wr_accept_lo) accepted[31:0] <= req.wdata;
      if (wr_accept_hi) accepted[63:32] <= req.wdata;
      if (wr_ctrl) ctrl <= req.wdata & ~(32'h1 << CTRL_COMMIT);
      if (wr_options) options <= req.wdata;
      if (commit && !commit_fail) negotiated_out <= next_negotiated; // RULE14
    end
  end

  always_comb begin
    flags.compliance = negotiated_out[COMPLIANCE_BIT];
    flags.platform_access = negotiated_out[PLATFORM_ACCESS_BIT];
    flags.in_order = negotiated_out[IN_ORDER_BIT];
    flags.order_platform = negotiated_out[ORDER_PLATFORM_BIT];
    flags.sriov = negotiated_out[SRIOV_BIT];
    flags.notify_empty = negotiated_out[NOTIFY_EMPTY_BIT];
    flags.any_layout = negotiated_out[ANY_LAYOUT_BIT];
  end

  wire logic operating = (state == ST_RUN) || (state == ST_EMULATED);
  assign device_run_out = operating;
  assign device_failed_out = (state == ST_FAILED); // RULE2
  assign emulation_mode_out = (state == ST_EMULATED); // RULE5
  assign in_order_active_out = operating && flags.in_order; // RULE4

  //////////////////////////////////////////////////////////////////////////////
  // ordered use and notify-on-empty
  logic order_err;
  logic [IDX_W-1:0] expected_idx;
  order_tracker #(.IDX_W(IDX_W)) u_order (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .enable_in(clk_en_in),
    .active_in(in_order_active_out), // RULE4
    .used_valid_in(used_valid_in),
    .used_idx_in(used_idx_in),
    .order_ok_out(order_ok_out),
    .order_err_out(order_err),
    .expected_out(expected_idx)
  );

  logic empty_q;
  wire logic empty_rise = ring_empty_in && !empty_q;
  // suppression is overridden when the feature is in force
  wire logic next_notify = operating && empty_rise
    && (flags.notify_empty || !notify_suppressed_in); // RULE8

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      empty_q <= 1'b0;
      used_notify_out <= 1'b0;
    end else if (clk_en_in) begin
      empty_q <= ring_empty_in;
      used_notify_out <= next_notify;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // interrupts
  logic [IRQ_W-1:0] irq_events;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  always_comb begin
    irq_events = '0;
    irq_events[IRQ_COMMIT] = commit && !commit_fail;
    irq_events[IRQ_FAILED] = commit && commit_fail;
    irq_events[IRQ_EMPTY_NOTIFY] = next_notify;
    irq_events[IRQ_ORDER_ERR] = order_err;
  end

  irq_block #(.WIDTH(IRQ_W)) u_irq (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .enable_in(clk_en_in),
    .event_in(irq_events),
    .clear_in(wr_irq_clear ? req.wdata[IRQ_W-1:0] : {IRQ_W{1'b0}}),
    .enable_wr_in(wr_irq_enable),
    .enable_data_in(req.wdata[IRQ_W-1:0]),
    .status_out(irq_status),
    .mask_out(irq_mask),
    .irq_out(irq_out)
  );

  //////////////////////////////////////////////////////////////////////////////
  // read data, one cycle after the strobe
  wire logic [31:0] state_word = {{(32 - IDX_W){1'b0}}, expected_idx} << 8
    | {28'h0, device_failed_out, emulation_mode_out, device_run_out, in_order_active_out};
  logic [31:0] next_rdata;
  always_comb begin
    if (!req.rd) next_rdata = 32'h0;
    else if (req.addr == OFF_OFFER_LO) next_rdata = offered_out[31:0];
    else if (req.addr == OFF_OFFER_HI) next_rdata = offered_out[63:32];
    else if (req.addr == OFF_ACCEPT_LO) next_rdata = accepted[31:0];
    else if (req.addr == OFF_ACCEPT_HI) next_rdata = accepted[63:32];
    else if (req.addr == OFF_NEG_LO) next_rdata = negotiated_out[31:0];
    else if (req.addr == OFF_NEG_HI) next_rdata = negotiated_out[63:32];
    else if (req.addr == OFF_CTRL) next_rdata = ctrl;
    else if (req.addr == OFF_STATE) next_rdata = state_word;
    else if (req.addr == OFF_IRQ_STATUS) next_rdata = {{(32 - IRQ_W){1'b0}}, irq_status};
    else if (req.addr == OFF_IRQ_ENABLE) next_rdata = {{(32 - IRQ_W){1'b0}}, irq_mask};
    else if (req.addr == OFF_OPTIONS) next_rdata = options;
    else next_rdata = 32'h0;
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      rdata_out <= 32'h0;
    end else if (clk_en_in) begin
      rdata_out <= next_rdata;
    end
  end
endmodule
`default_nettype wire

// File: sim/feature_negotiation_sva.sv
// Purpose: port-level checks on the reserved feature negotiation block
// Assumes: one clock domain, asynchronous active-high reset
// Notes: bound to every feature_negotiation instance at the foot of this file
`default_nettype none
module feature_negotiation_sva
  import feature_pkg::*;
#(
  parameter int unsigned IDX_W = 16
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [31:0] rdata_out,
  input wire logic transitional_in,
  input wire logic translated_access_in,
  input wire logic pci_addin_card_in,
  input wire logic is_pci_in,
  input wire logic sriov_capability_in,
  input wire logic in_order_support_in,
  input wire logic ring_empty_in,
  input wire logic notify_suppressed_in,
  input wire logic used_valid_in,
  input wire logic [IDX_W-1:0] used_idx_in,
  input wire logic [FEAT_W-1:0] offered_out,
  input wire logic [FEAT_W-1:0] negotiated_out,
  input wire logic device_run_out,
  input wire logic device_failed_out,
  input wire logic emulation_mode_out,
  input wire logic in_order_active_out,
  input wire logic used_notify_out,
  input wire logic order_ok_out,
  input wire logic irq_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  ////////////////////////////////////////////////////////////////////////////////
  property p_compliance;
    clk_en_in && !reset_in |=> offered_out[COMPLIANCE_BIT];
  endproperty
  a_compliance: assert property (p_compliance)
    else $error("compliance bit not offered");
  property p_layout;
    clk_en_in && !reset_in |=> offered_out[ANY_LAYOUT_BIT] == $past(transitional_in);
  endproperty
  a_layout: assert property (p_layout)
    else $error("layout offer does not follow transitional strap");
  property p_access;
    clk_en_in && !reset_in
      |=> offered_out[PLATFORM_ACCESS_BIT] == $past(translated_access_in | pci_addin_card_in);
  endproperty
  a_access: assert property (p_access)
    else $error("platform access offer wrong");
  property p_sriov;
    clk_en_in && !reset_in |=> offered_out[SRIOV_BIT] == $past(is_pci_in & sriov_capability_in);
  endproperty
  a_sriov: assert property (p_sriov)
    else $error("sriov offer wrong");
  property p_bit30;
    !offered_out[EARLY_BROKEN_BIT] && !negotiated_out[EARLY_BROKEN_BIT];
  endproperty
  a_bit30: assert property (p_bit30)
    else $error("bit 30 offered or negotiated");
  property p_neg_compliance;
    negotiated_out != '0 |-> negotiated_out[COMPLIANCE_BIT];
  endproperty
  a_neg_compliance: assert property (p_neg_compliance)
    else $error("negotiated set lacks compliance bit");
  property p_failed;
    device_failed_out |=> device_failed_out && !device_run_out;
  endproperty
  a_failed: assert property (p_failed)
    else $error("failed state left before reset");
  property p_emulated;
    emulation_mode_out |-> !negotiated_out[ORDER_PLATFORM_BIT] && !device_failed_out;
  endproperty
  a_emulated: assert property (p_emulated)
    else $error("emulation with ordering negotiated");
  property p_in_order;
    in_order_active_out |-> negotiated_out[IN_ORDER_BIT];
  endproperty
  a_in_order: assert property (p_in_order)
    else $error("in-order active without negotiation");
  property p_order_idle;
    !in_order_active_out |-> order_ok_out;
  endproperty
  a_order_idle: assert property (p_order_idle)
    else $error("order error while in-order inactive");
  property p_notify;
    $rose(ring_empty_in) && device_run_out && clk_en_in
      && (!notify_suppressed_in || negotiated_out[NOTIFY_EMPTY_BIT]) |-> ##[1:2] used_notify_out;
  endproperty
  a_notify: assert property (p_notify)
    else $error("no notification on empty ring");
  property p_quiet;
    $rose(ring_empty_in) && notify_suppressed_in && !negotiated_out[NOTIFY_EMPTY_BIT]
      |=> !used_notify_out;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("notification while suppressed");
  c_run: cover property ($rose(device_run_out));
  c_emul: cover property ($rose(emulation_mode_out));
  c_fail: cover property ($rose(device_failed_out));
  c_notify: cover property (used_notify_out);
endmodule
bind feature_negotiation feature_negotiation_sva #(.IDX_W(IDX_W)) u_sva (.*);
`default_nettype wire

// File: sim/feature_negotiation_tb.sv
// Purpose: self-checking bench for reserved feature negotiation
// Assumes: read data stands only in the cycle after the read strobe
// Notes: failing commits run last because the failed state sticks
`default_nettype none
module feature_negotiation_tb
  import feature_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned IDX_W = 4;
  localparam logic [63:0] ALL = 64'hffff_ffff_ffff_ffff;
  logic clk_in, reset_in, clk_en_in, wr_in, rd_in, used_valid_in;
  logic [ADDR_W-1:0] addr_in;
  logic [31:0] wdata_in, rdata_out;
  logic transitional_in, translated_access_in, pci_addin_card_in, is_pci_in;
  logic sriov_capability_in, in_order_support_in, ring_empty_in, notify_suppressed_in;
  logic [IDX_W-1:0] used_idx_in;
  logic [FEAT_W-1:0] offered_out, negotiated_out, ofs;
  logic device_run_out, device_failed_out, emulation_mode_out, in_order_active_out;
  logic used_notify_out, order_ok_out, irq_out;
  int err_count, comparisons;

  feature_negotiation #(.IDX_W(IDX_W)) dut (.*);

  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
    #1;
  endtask
  task automatic rc(input string name, input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    chk(name, exp, rdata_out);
  endtask
  task automatic commit(input logic [63:0] acc, input logic [31:0] ctrl);
    wr(OFF_ACCEPT_LO, acc[31:0]);
    wr(OFF_ACCEPT_HI, acc[63:32]);
    // strict bits must stand in ctrl before the commit strobe reads them
    wr(OFF_CTRL, ctrl);
    wr(OFF_CTRL, ctrl | 32'h0000_0001);
  endtask
  // strap order: transitional, translated, add-in card, pci, sriov cap, in-order
  task automatic straps(input logic [5:0] s);
    {transitional_in, translated_access_in, pci_addin_card_in} <= s[5:3];
    {is_pci_in, sriov_capability_in, in_order_support_in} <= s[2:0];
    repeat (2) @(posedge clk_in);
    #1;
  endtask
  function automatic logic [63:0] exp_offer(input logic [5:0] s, input logic [1:0] opt);
    logic [63:0] e;
    e = '0;
    e[NOTIFY_EMPTY_BIT] = s[5] & opt[OPT_NOTIFY_EMPTY];
    e[ANY_LAYOUT_BIT] = s[5];
    e[COMPLIANCE_BIT] = 1'b1;
    e[PLATFORM_ACCESS_BIT] = s[4] | s[3];
    e[IN_ORDER_BIT] = s[0];
    e[ORDER_PLATFORM_BIT] = s[3] | opt[OPT_ORDER_PLATFORM];
    e[SRIOV_BIT] = s[2] & s[1];
    return e;
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rc("options", OFF_OPTIONS, 32'h0000_0003);
    rc("ctrl", OFF_CTRL, 32'h0000_0000);
    rc("irq enable", OFF_IRQ_ENABLE, 32'h0000_0000);
    rc("irq status", OFF_IRQ_STATUS, 32'h0000_0000);
    rc("unmapped", 4'hc, 32'h0000_0000);
    chk("negotiated", '0, negotiated_out);
    $display("register reset test done");
  endtask
  task automatic t_offer();
    logic [5:0] tbl [5] = '{6'b000000, 6'b110101, 6'b001011, 6'b111111, 6'b111111};
    for (int i = 0; i < 5; i++) begin
      if (i == 4) wr(OFF_OPTIONS, 32'h0000_0000);
      straps(tbl[i]);
      ofs = exp_offer(tbl[i], (i == 4) ? 2'b00 : 2'b11);
      chk("offered", ofs, offered_out);
      rc("offer lo", OFF_OFFER_LO, ofs[31:0]);
      rc("offer hi", OFF_OFFER_HI, ofs[63:32]);
    end
    wr(OFF_OPTIONS, 32'h0000_0003);
    straps(6'b111111);
    $display("offer test done");
  endtask
  task automatic t_commit();
    ofs = exp_offer(6'b111111, 2'b11);
    commit(ALL & ~(64'h1 << ORDER_PLATFORM_BIT), 32'h0);
    chk("negotiated", ofs & ~(64'h1 << ORDER_PLATFORM_BIT), negotiated_out);
    chk("emulated", 1'b1, emulation_mode_out);
    rc("accept hi", OFF_ACCEPT_HI, 32'hffff_ffef);
    rc("state", OFF_STATE, 32'h0000_0007);
    commit(ALL, 32'h0);
    chk("run", 1'b1, device_run_out);
    chk("emulated", 1'b0, emulation_mode_out);
    rc("neg lo", OFF_NEG_LO, ofs[31:0]);
    rc("neg hi", OFF_NEG_HI, ofs[63:32]);
    $display("commit test done");
  endtask
  task automatic use_buf(input logic [3:0] idx, input logic ok);
    @(posedge clk_in);
    used_valid_in <= 1'b1;
    used_idx_in <= idx;
    #1;
    chk("order ok", ok, order_ok_out);
    @(posedge clk_in);
    used_valid_in <= 1'b0;
  endtask
  task automatic t_order();
    chk("in order", 1'b1, in_order_active_out);
    use_buf(4'h0, 1'b1);
    use_buf(4'h1, 1'b1);
    use_buf(4'h3, 1'b0);
    rc("state idx", OFF_STATE, 32'h0000_0203);
    use_buf(4'h2, 1'b1);
    $display("order test done");
  endtask
  task automatic pulses(input logic supp, input int exp);
    int n;
    n = 0;
    @(posedge clk_in);
    notify_suppressed_in <= supp;
    ring_empty_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    ring_empty_in <= 1'b1;
    repeat (4) begin
      @(posedge clk_in);
      #1;
      n += int'(used_notify_out === 1'b1);
    end
    chk("notify count", exp, n);
  endtask
  task automatic t_notify();
    pulses(1'b1, 1);
    commit(ALL & ~(64'h1 << NOTIFY_EMPTY_BIT), 32'h0);
    pulses(1'b1, 0);
    pulses(1'b0, 1);
    $display("notify test done");
  endtask
  task automatic t_irq();
    wr(OFF_IRQ_ENABLE, 32'h0000_000f);
    chk("irq", 1'b1, irq_out);
    rc("irq status", OFF_IRQ_STATUS, 32'h0000_000d);
    wr(OFF_IRQ_ENABLE, 32'h0000_0000);
    chk("irq masked", 1'b0, irq_out);
    wr(OFF_IRQ_ENABLE, 32'h0000_000f);
    wr(OFF_IRQ_CLEAR, 32'h0000_000f);
    chk("irq cleared", 1'b0, irq_out);
    rc("irq status", OFF_IRQ_STATUS, 32'h0000_0000);
    $display("interrupt test done");
  endtask
  task automatic do_reset();
    reset_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    reset_in <= 1'b0;
  endtask
  task automatic t_fail();
    int bits [4] = '{COMPLIANCE_BIT, ANY_LAYOUT_BIT, PLATFORM_ACCESS_BIT, ORDER_PLATFORM_BIT};
    logic [31:0] ctl [4] = '{32'h0, 32'h0, 32'h2, 32'h4};
    for (int i = 0; i < 4; i++) begin
      do_reset();
      commit(ALL & ~(64'h1 << bits[i]), ctl[i]);
      chk("failed", 1'b1, device_failed_out);
      chk("negotiated", '0, negotiated_out);
      rc("irq status", OFF_IRQ_STATUS, 32'h0000_0002);
      commit(ALL, 32'h0);
      chk("still failed", 1'b1, device_failed_out);
    end
    $display("failure test done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk_in);
    err_count++;
    finish_test();
  end
  initial begin
    {reset_in, clk_en_in, wr_in, rd_in, used_valid_in} = 5'b11000;
    {ring_empty_in, notify_suppressed_in, addr_in, wdata_in, used_idx_in} = '0;
    {transitional_in, translated_access_in, pci_addin_card_in, is_pci_in} = '0;
    {sriov_capability_in, in_order_support_in} = '0;
    do_reset();
    t_regs();
    t_offer();
    t_commit();
    t_order();
    t_notify();
    t_irq();
    t_fail();
    finish_test();
  end
endmodule
`default_nettype wire
